/* File: cpu_core_pkg.sv */
// Purpose: Shared constants and types for the sensor CPU fetch/decode core
// Assumes: 8-bit program memory answering while the read strobe stands
// Notes: Opcode values and address widths are named once here

package cpu_core_pkg;

    // ------------------------------------------------------------
    // Widths and address space
    // ------------------------------------------------------------
    localparam int DATA_W = 16;                 // CPU register width
    localparam int PADDR_W = 12;                // Decoded program address bits
    localparam int REG_COUNT = 16;              // CPU register file size
    localparam logic [15:0] PC_RESET = 16'h0000; // Fetch start address
    localparam logic [15:0] REG_RESET = 16'h0000; // Register reset value
    localparam logic [15:0] CLEAR_VALUE = 16'h0000; // Value written by clear
    localparam logic [3:0] ACCUM_SEL = 4'h0;    // Accumulator register index
    localparam logic [15:0] PC_STEP = 16'h0001; // One byte per fetch

    // ------------------------------------------------------------
    // Instruction byte fields
    // ------------------------------------------------------------
    localparam int OPC_MSB = 7;                 // Operation code top bit
    localparam int OPC_LSB = 4;                 // Operation code low bit
    localparam int SEL_MSB = 3;                 // Register selector top bit
    localparam int SEL_LSB = 0;                 // Register selector low bit

    // Operation codes handled here
    localparam logic [3:0] load_immediate_op = 4'h0; // Two operand bytes follow
    localparam logic [3:0] clear_reg_op = 4'h1;      // Clear selected reg
    localparam logic [3:0] and_accum_op = 4'h2;      // Accum AND reg
    localparam logic [3:0] or_accum_op = 4'h3;       // Accum OR reg
    localparam logic [3:0] add_accum_op = 4'h4;      // Accum plus reg
    localparam logic [3:0] store_accum_op = 4'h5;    // Reg gets accum

    // Serial command byte that halts execution
    localparam logic [7:0] HALT_CMD = 8'h78;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_FETCH = 5'b0_0001,   // Address out for opcode byte
        ST_DECODE = 5'b0_0010,  // Opcode byte on memory data
        ST_OPHI = 5'b0_0100,    // High operand byte on memory data
        ST_OPLO = 5'b0_1000,    // Low operand byte on memory data
        ST_HALT = 5'b1_0000     // Execution stopped
    } core_state_type;

    // Hook handed to the execution units of the other opcodes
    typedef struct packed {
        logic valid;            // One-cycle strobe
        logic [3:0] opcode;     // Operation code 6..15
        logic [3:0] sel;        // Register selector
        logic [15:0] pc;        // Address of the instruction
    } ext_hook_type;

endpackage

/* File: cpu_core_ops.sv */
// Purpose: Fetch and decode core running load, clear, and, or, add, store
// Assumes: Memory answers in the cycle that mem_rd stands high
// Notes: Opcodes 6..15 leave through a hook and the core waits for done
//
// Contract
// - Fetch from zero, step one byte upward
// - Only low twelve address bits reach memory
// - Bits 7-4 opcode, bits 3-0 register
// - All ops one byte, load takes two more
// - Load: high byte then low, PC plus three
// - Clear writes zero into selected register
// - Accumulator becomes accumulator AND register
// - Accumulator becomes accumulator OR register
// - Accumulator gets sixteen-bit sum, carry dropped
// - Selected register takes accumulator copy
// - Single ops: PC plus one, one destination
// - Selector reaches all sixteen registers, accumulator too
// - Halt byte received stops instruction execution
// - Program memory is read-only to the core

`timescale 1ns/1ps

module cpu_core_ops #(
    parameter int NREGS = cpu_core_pkg::REG_COUNT // Register file depth
) (
    input wire logic clk,                        // 125 MHz core clock
    input wire logic rst_n,                      // Synchronous, active low
    input wire logic clk_en,                     // Freezes all state when low
    input wire logic [7:0] mem_rdata,            // Program memory byte
    input wire logic cmd_valid,                  // Serial command byte strobe
    input wire logic [7:0] cmd_byte,             // Serial command byte
    input wire logic resume,                     // Release from halt
    input wire logic hook_done,                  // External op finished
    input wire logic hook_branch,                // External op set a new PC
    input wire logic [15:0] hook_pc,             // New PC from external op
    output logic [11:0] mem_addr,                // Program memory address
    output logic mem_rd,                         // Program memory read strobe
    output cpu_core_pkg::ext_hook_type hook,     // External op request
    output logic [15:0] pc_out,                  // Program counter view
    output logic [15:0] accum_out,               // Accumulator view
    output logic halted                          // Core stopped
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cpu_core_pkg::core_state_type state_r, state_nxt; // Sequencer
    logic [15:0] pc_r, pc_nxt;                    // Program counter
    logic [15:0] regs_r [NREGS];                  // CPU registers
    logic [15:0] wdata_nxt;                       // Register write value
    logic [3:0] wsel_nxt;                         // Register write index
    logic wen_nxt;                                // Register write enable
    logic [3:0] sel_r, sel_nxt;                   // Held selector
    logic [7:0] hi_r, hi_nxt;                     // Held operand high byte
    logic [11:0] addr_r, addr_nxt;                // Memory address out
    logic rd_r, rd_nxt;                           // Memory read strobe
    cpu_core_pkg::ext_hook_type hook_r, hook_nxt; // Hook request
    logic wait_r, wait_nxt;                       // Waiting on hook
    logic halted_r, halted_nxt;                   // Halt flag out
    logic [3:0] opc;                              // Decoded opcode
    logic [3:0] sel;                              // Decoded selector
    logic [15:0] xval;                            // Selected register value
    logic [15:0] acc;                             // Accumulator value
    logic halt_req;                               // Halt byte seen

    assign opc = mem_rdata[cpu_core_pkg::OPC_MSB:cpu_core_pkg::OPC_LSB];
    assign sel = mem_rdata[cpu_core_pkg::SEL_MSB:cpu_core_pkg::SEL_LSB];
    assign xval = regs_r[sel];
    assign acc = regs_r[cpu_core_pkg::ACCUM_SEL];
    assign halt_req = cmd_valid && (cmd_byte == cpu_core_pkg::HALT_CMD);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Address is issued one cycle ahead; the byte arrives next state.
    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        sel_nxt = sel_r;
        hi_nxt = hi_r;
        addr_nxt = addr_r;
        rd_nxt = 1'b0;
        wen_nxt = 1'b0;
        wsel_nxt = sel;
        wdata_nxt = cpu_core_pkg::CLEAR_VALUE;
        hook_nxt = '0;
        wait_nxt = wait_r;
        halted_nxt = halted_r;
        case (state_r)
            // Show the opcode address
            cpu_core_pkg::ST_FETCH: begin
                if (!wait_r) begin
                    addr_nxt = pc_r[cpu_core_pkg::PADDR_W-1:0];
                    rd_nxt = 1'b1;
                    state_nxt = cpu_core_pkg::ST_DECODE;
                end else if (hook_done) begin
                    // Hook owns PC flow for its own opcodes
                    wait_nxt = 1'b0;
                    pc_nxt = hook_branch ? hook_pc : pc_r + cpu_core_pkg::PC_STEP;
                end
            end
            // Opcode byte present: execute or start operand reads
            cpu_core_pkg::ST_DECODE: begin
                state_nxt = cpu_core_pkg::ST_FETCH;
                pc_nxt = pc_r + cpu_core_pkg::PC_STEP;
                case (opc)
                    cpu_core_pkg::load_immediate_op: begin
                        sel_nxt = sel;
                        addr_nxt = pc_nxt[cpu_core_pkg::PADDR_W-1:0];
                        rd_nxt = 1'b1;
                        state_nxt = cpu_core_pkg::ST_OPHI;
                    end
                    cpu_core_pkg::clear_reg_op: begin
                        wen_nxt = 1'b1;
                        wdata_nxt = cpu_core_pkg::CLEAR_VALUE;
                    end
                    cpu_core_pkg::and_accum_op: begin
                        wen_nxt = 1'b1;
                        wsel_nxt = cpu_core_pkg::ACCUM_SEL;
                        wdata_nxt = acc & xval;
                    end
                    cpu_core_pkg::or_accum_op: begin
                        wen_nxt = 1'b1;
                        wsel_nxt = cpu_core_pkg::ACCUM_SEL;
                        wdata_nxt = acc | xval;
                    end
                    cpu_core_pkg::add_accum_op: begin
                        wen_nxt = 1'b1;
                        wsel_nxt = cpu_core_pkg::ACCUM_SEL;
                        wdata_nxt = 16'(acc + xval);
                    end
                    cpu_core_pkg::store_accum_op: begin
                        wen_nxt = 1'b1;
                        wdata_nxt = acc;
                    end
                    default: begin
                        // Foreign opcode: hand off, keep PC until done
                        pc_nxt = pc_r;
                        hook_nxt.valid = 1'b1;
                        hook_nxt.opcode = opc;
                        hook_nxt.sel = sel;
                        hook_nxt.pc = pc_r;
                        wait_nxt = 1'b1;
                    end
                endcase
            end
            // High operand byte present
            cpu_core_pkg::ST_OPHI: begin
                hi_nxt = mem_rdata;
                pc_nxt = pc_r + cpu_core_pkg::PC_STEP;
                addr_nxt = pc_nxt[cpu_core_pkg::PADDR_W-1:0];
                rd_nxt = 1'b1;
                state_nxt = cpu_core_pkg::ST_OPLO;
            end
            // Low operand byte present: write and step past it
            cpu_core_pkg::ST_OPLO: begin
                wen_nxt = 1'b1;
                wsel_nxt = sel_r;
                wdata_nxt = {hi_r, mem_rdata};
                pc_nxt = pc_r + cpu_core_pkg::PC_STEP;
                state_nxt = cpu_core_pkg::ST_FETCH;
            end
            // Stopped until released
            cpu_core_pkg::ST_HALT: begin
                if (resume) begin
                    halted_nxt = 1'b0;
                    state_nxt = cpu_core_pkg::ST_FETCH;
                end
            end
            default: begin
                state_nxt = cpu_core_pkg::ST_FETCH;
            end
        endcase
        // Halt wins over the next state; a single op in decode still writes and steps PC, a pending hook is abandoned
        if (halt_req) begin
            state_nxt = cpu_core_pkg::ST_HALT;
            halted_nxt = 1'b1;
            rd_nxt = 1'b0;
            wait_nxt = 1'b0;
            hook_nxt = '0;
            // A load cut short leaves its register untouched
            if (state_r != cpu_core_pkg::ST_DECODE) begin
                wen_nxt = 1'b0;
            end
            if (state_r == cpu_core_pkg::ST_OPHI ||
                state_r == cpu_core_pkg::ST_OPLO) begin
                pc_nxt = pc_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= cpu_core_pkg::ST_FETCH;
            pc_r <= cpu_core_pkg::PC_RESET;
            sel_r <= '0;
            hi_r <= '0;
            addr_r <= '0;
            rd_r <= 1'b0;
            hook_r <= '0;
            wait_r <= 1'b0;
            halted_r <= 1'b0;
            for (int i = 0; i < NREGS; i++) begin
                regs_r[i] <= cpu_core_pkg::REG_RESET;
            end
        end else if (clk_en) begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            sel_r <= sel_nxt;
            hi_r <= hi_nxt;
            addr_r <= addr_nxt;
            rd_r <= rd_nxt;
            hook_r <= hook_nxt;
            wait_r <= wait_nxt;
            halted_r <= halted_nxt;
            // Only one destination written per instruction
            if (wen_nxt) begin
                regs_r[wsel_nxt] <= wdata_nxt;
            end
        end
    end

    // Outputs straight from flops
    assign mem_addr = addr_r;
    assign mem_rd = rd_r;
    assign hook = hook_r;
    assign pc_out = pc_r;
    assign accum_out = regs_r[cpu_core_pkg::ACCUM_SEL];
    assign halted = halted_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence load_seen_s;
        clk_en && state_r == cpu_core_pkg::ST_DECODE &&
        opc == cpu_core_pkg::load_immediate_op && !halt_req;
    endsequence

    sequence single_seen_s;
        clk_en && state_r == cpu_core_pkg::ST_DECODE &&
        opc >= cpu_core_pkg::clear_reg_op &&
        opc <= cpu_core_pkg::store_accum_op && !halt_req;
    endsequence

    reset_fetch_zero_a: assert property (
        $rose(rst_n) |-> pc_r == cpu_core_pkg::PC_RESET)
        else $error("pc not zero after reset");
    addr_low_bits_a: assert property (
        rd_r |-> addr_r == $past(pc_nxt[11:0]))
        else $error("address not low bits of pc");
    load_pc_three_a: assert property (
        load_seen_s ##1 (clk_en && !halt_req)[*2]
        |=> pc_r == $past(pc_r, 3) + 16'd3)
        else $error("load did not step pc by three");
    load_value_a: assert property (
        load_seen_s ##1 (clk_en && !halt_req)[*2]
        |=> regs_r[sel_r] == {hi_r, $past(mem_rdata)})
        else $error("load value wrong");
    single_pc_one_a: assert property (
        single_seen_s |=> pc_r == $past(pc_r) + 16'd1 &&
        state_r == cpu_core_pkg::ST_FETCH)
        else $error("single op pc step wrong");
    clear_zero_a: assert property (
        clk_en && state_r == cpu_core_pkg::ST_DECODE &&
        opc == cpu_core_pkg::clear_reg_op |=> regs_r[$past(sel)] == 16'h0000)
        else $error("clear did not zero register");
    add_wrap_a: assert property (
        clk_en && state_r == cpu_core_pkg::ST_DECODE &&
        opc == cpu_core_pkg::add_accum_op && sel != 4'h0
        |=> accum_out == 16'($past(acc) + $past(xval)))
        else $error("add result wrong");
    // Logic ops rewrite only the accumulator; the operand stays put
    and_accum_a: assert property (
        clk_en && state_r == cpu_core_pkg::ST_DECODE &&
        opc == cpu_core_pkg::and_accum_op
        |=> accum_out == ($past(acc) & $past(xval)) &&
        regs_r[$past(sel)] == $past(xval))
        else $error("and result wrong");
    or_accum_a: assert property (
        clk_en && state_r == cpu_core_pkg::ST_DECODE &&
        opc == cpu_core_pkg::or_accum_op
        |=> accum_out == ($past(acc) | $past(xval)) &&
        regs_r[$past(sel)] == $past(xval))
        else $error("or result wrong");
    // Store copies out; the accumulator keeps its value
    store_copy_a: assert property (
        clk_en && state_r == cpu_core_pkg::ST_DECODE &&
        opc == cpu_core_pkg::store_accum_op
        |=> regs_r[$past(sel)] == $past(acc) && accum_out == $past(acc))
        else $error("store copy wrong");
    halt_stop_a: assert property (
        clk_en && halt_req |=> halted && !mem_rd)
        else $error("halt byte not obeyed");
    hook_route_a: assert property (
        clk_en && state_r == cpu_core_pkg::ST_DECODE && opc > 4'h5 &&
        !halt_req |=> hook.valid && hook.opcode == $past(opc) &&
        pc_r == $past(pc_r))
        else $error("foreign opcode not routed");

endmodule

/* File: tb.sv */
// Purpose: Self-checking bench for the sensor CPU fetch/decode core
// Assumes: Bench ROM answers while mem_rd stands, as the core expects
// Notes: Rows hold a program; halt, branch and reset are tested by hand

`timescale 1ns/1ps

module tb;

    // ------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------
    typedef struct {
        logic [7:0] b0, b1, b2; // Opcode byte and operand bytes
        int len;                // Bytes in the instruction
        logic [15:0] acc;       // Accumulator after the instruction
        int cyc;                // Cycles it takes, 0 means skip
    } row_type;

    logic clk = 1'b0;                         // Core clock
    logic rst_n = 1'b0;                       // Reset, active low
    logic clk_en = 1'b1;                      // Clock enable
    logic [7:0] mem_rdata = 8'h00;            // ROM answer
    logic cmd_valid = 1'b0;                   // Command strobe
    logic [7:0] cmd_byte = 8'h00;             // Command byte
    logic resume = 1'b0;                      // Leave halt
    logic hook_done = 1'b0;                   // Foreign op finished
    logic hook_branch = 1'b0;                 // Foreign op jumps
    logic [15:0] hook_pc = 16'h0000;          // Jump target
    logic [11:0] mem_addr;                    // Program address
    logic mem_rd;                             // Read strobe
    cpu_core_pkg::ext_hook_type hook;         // Foreign op request
    cpu_core_pkg::ext_hook_type seen_hook;    // Last request seen
    logic [15:0] pc_out, accum_out;           // Core views
    logic halted;                             // Core stopped
    logic br_en = 1'b0;                       // Next hook op branches
    logic [15:0] br_pc = 16'h0000;            // Its target
    logic [7:0] rom [4096];                   // Program store
    logic [15:0] addr [17];                   // Row start addresses
    logic [15:0] p;                           // Saved program counter
    int n_mismatch = 0;                       // Mismatches found
    int num_checks = 0;                       // Comparisons made
    int rd_count = 0;                         // Reads issued
    int n, a, r;                              // Scratch

    // Sum wraps, selector 0 is the accumulator itself
    row_type rows [17] = '{
        '{8'h00, 8'h12, 8'h34, 3, 16'h1234, 0},
        '{8'h55, 8'h00, 8'h00, 1, 16'h1234, 2},
        '{8'h03, 8'hF0, 8'hF0, 3, 16'h1234, 4},
        '{8'h23, 8'h00, 8'h00, 1, 16'h1030, 2},
        '{8'h35, 8'h00, 8'h00, 1, 16'h1234, 2},
        '{8'h0F, 8'hFF, 8'hFF, 3, 16'h1234, 4},
        '{8'h4F, 8'h00, 8'h00, 1, 16'h1233, 2},
        '{8'h40, 8'h00, 8'h00, 1, 16'h2466, 2},
        '{8'h15, 8'h00, 8'h00, 1, 16'h2466, 2},
        '{8'h10, 8'h00, 8'h00, 1, 16'h0000, 2},
        '{8'h35, 8'h00, 8'h00, 1, 16'h0000, 2},
        '{8'h33, 8'h00, 8'h00, 1, 16'hF0F0, 2},
        '{8'h50, 8'h00, 8'h00, 1, 16'hF0F0, 2},
        '{8'h67, 8'h00, 8'h00, 1, 16'hF0F0, 0},
        '{8'hF0, 8'h00, 8'h00, 1, 16'hF0F0, 0},
        '{8'h43, 8'h00, 8'h00, 1, 16'hE1E0, 0},
        '{8'h1F, 8'h00, 8'h00, 1, 16'hE1E0, 2}
    };

    // One compare; an unknown matches only an unknown
    `define CHK(got, want) begin \
        num_checks++; \
        if ((got) !== (want)) begin \
            n_mismatch++; \
            $display("wrong value at %0t: got %h want %h", $time, \
                (got), (want)); \
        end \
    end

    cpu_core_ops i_cpu_core_ops (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .mem_rdata(mem_rdata), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .resume(resume), .hook_done(hook_done),
        .hook_branch(hook_branch), .hook_pc(hook_pc),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .hook(hook),
        .pc_out(pc_out), .accum_out(accum_out), .halted(halted)
    );

    // ------------------------------------------------------------
    // Clock, ROM and foreign op responder
    // ------------------------------------------------------------
    // Clock at 125 MHz
    always #4 clk = ~clk;

    // Read-only store; the byte stands in the cycle mem_rd is high,
    // and between reads the data bus toggles on purpose
    always @(posedge clk) begin
        #1;
        if (mem_rd === 1'b1) begin
            mem_rdata = rom[mem_addr];
            rd_count++;
        end else begin
            mem_rdata = ~mem_rdata;
        end
    end

    // Finish every foreign op one cycle after its request
    always @(posedge clk) begin
        if (hook.valid === 1'b1) begin
            seen_hook <= hook;
            hook_done <= #1 1'b1;
            hook_branch <= #1 br_en;
            hook_pc <= #1 br_pc;
        end else begin
            hook_done <= #1 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Count cycles until the program counter shows a value, bounded
    task automatic wait_pc(input logic [15:0] want, output int cnt);
        cnt = 0;
        while (pc_out !== want && cnt < 50) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        `CHK(pc_out, want)
    endtask

    // Wait k rising edges, then step 1 ns past the last one
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Watchdog at 3000 cycles, far beyond the hundred or so cycles the run needs
    initial begin
        #24000;
        n_mismatch++;
        report_and_stop;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        for (a = 0; a < 4096; a++) rom[a] = 8'h1F;
        a = 0;
        for (r = 0; r < 17; r++) begin
            addr[r] = a[15:0];
            rom[a] = rows[r].b0;
            if (rows[r].len == 3) begin
                rom[a + 1] = rows[r].b1;
                rom[a + 2] = rows[r].b2;
            end
            a += rows[r].len;
        end
        rom[a] = 8'h6A;
        rom[256] = 8'h00;
        rom[257] = 8'hAB;
        rom[258] = 8'hCD;
        // Reset values, checked while reset is held
        tick(3);
        `CHK(pc_out, 16'h0000)
        `CHK(accum_out, 16'h0000)
        `CHK(halted, 1'b0)
        `CHK(mem_rd, 1'b0)
        `CHK(hook.valid, 1'b0)
        rst_n = 1'b1;
        // Program rows
        for (r = 0; r < 17; r++) begin
            wait_pc(addr[r] + rows[r].len[15:0], n);
            `CHK(accum_out, rows[r].acc)
            if (rows[r].cyc != 0) `CHK(n, rows[r].cyc)
            if (rows[r].b0[7:4] >= 4'h6) begin
                `CHK(seen_hook.opcode, rows[r].b0[7:4])
                `CHK(seen_hook.sel, rows[r].b0[3:0])
                `CHK(seen_hook.pc, addr[r])
            end
        end
        // Jump above the space: upper address bits are dropped
        br_en = 1'b1;
        br_pc = 16'hF100;
        wait_pc(16'hF100, n);
        br_en = 1'b0;
        n = 0;
        while (mem_rd !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        `CHK(mem_addr, 12'h100)
        wait_pc(16'hF103, n);
        `CHK(accum_out, 16'hABCD)
        // A foreign command does not halt, the halt byte does
        cmd_valid = 1'b1;
        cmd_byte = 8'hF8;
        tick(1);
        cmd_valid = 1'b0;
        tick(3);
        `CHK(halted, 1'b0)
        cmd_valid = 1'b1;
        cmd_byte = 8'h78;
        tick(1);
        cmd_valid = 1'b0;
        tick(4);
        `CHK(halted, 1'b1)
        p = pc_out;
        a = rd_count;
        tick(10);
        `CHK(pc_out, p)
        `CHK(rd_count, a)
        // Leave halt, then freeze with the enable
        resume = 1'b1;
        tick(1);
        resume = 1'b0;
        wait_pc(p + 16'h0001, n);
        `CHK(halted, 1'b0)
        clk_en = 1'b0;
        tick(1);
        p = pc_out;
        tick(5);
        `CHK(pc_out, p)
        clk_en = 1'b1;
        // Second reset in mid-run restarts at zero
        rst_n = 1'b0;
        tick(1);
        rst_n = 1'b1;
        `CHK(pc_out, 16'h0000)
        `CHK(accum_out, 16'h0000)
        wait_pc(16'h0003, n);
        `CHK(accum_out, 16'h1234)
        report_and_stop;
    end

endmodule
